/* core/efd_pkg.sv */
// ****************************************
// Shared constants and types
// ****************************************
package efd_pkg;

	// Replication and record sizes
	localparam int NUM_STAGES = 4;
	localparam int REC_DEPTH = 12;
	localparam int NUM_EVT = 7;

	// Event bit positions
	localparam int EVT_START = 0;
	localparam int EVT_TRIP = 1;
	localparam int EVT_BLOCK = 2;
	localparam int EVT_RES_START = 3;
	localparam int EVT_CAP_START = 4;
	localparam int EVT_RES_TRIP = 5;
	localparam int EVT_CAP_TRIP = 6;

	// Program cycle and pre-trigger depths
	localparam int PROG_CYCLE_US = 5000;
	localparam int PRE_TRIG_MS = 20;
	localparam int PRE_FAULT_MS = 200;
	localparam int PRE_TRIG_CYC = PRE_TRIG_MS * 1000 / PROG_CYCLE_US;
	localparam int PRE_FAULT_CYC = PRE_FAULT_MS * 1000 / PROG_CYCLE_US;

	// Inrush limit reset value, 0.01 percent steps
	localparam logic [15:0] INRUSH_LIM_RST = 16'h0001;

	typedef enum logic [1:0] {COND_NORMAL, COND_START, COND_TRIP, COND_BLOCKED} efd_cond_e;
	typedef enum logic {FIXED_DELAY_MODE, INVERSE_DELAY_MODE} efd_dly_e;
	typedef enum logic [1:0] {GND_UNEARTHED, GND_COIL, GND_SOLID} efd_gnd_e;

	// Process data sampled every program cycle
	typedef struct packed {
		logic [15:0] residualCurrent;
		logic [15:0] faultCurrent;
		logic [15:0] capacitiveComponent;
		logic [15:0] resistiveComponent;
		logic [15:0] voltPct;
		logic [15:0] voltVolts;
		logic [15:0] angle;
	} efd_meas_s;

	// Per-stage settings
	typedef struct packed {
		logic inrushEn;
		logic [15:0] inrushLimit;
		efd_dly_e opMode;
		efd_dly_e rstMode;
		logic [23:0] opTarget;
		logic [23:0] rstTarget;
		logic [NUM_EVT-1:0] maskOn;
		logic [NUM_EVT-1:0] maskOff;
	} efd_cfg_s;

	localparam efd_cfg_s CFG_RST = '{inrushEn: 1'b0, inrushLimit: INRUSH_LIM_RST,
		opMode: FIXED_DELAY_MODE, rstMode: FIXED_DELAY_MODE, default: '0};

	// One fault record entry
	typedef struct packed {
		efd_cond_e cause;
		logic [31:0] stamp;
		logic [15:0] preTrig;
		efd_meas_s meas;
		logic [23:0] remaining;
		logic [2:0] setGroup;
		efd_gnd_e gnd;
		logic [15:0] preFault;
	} efd_rec_s;

	// Per-stage event pulses with stamp
	typedef struct packed {
		logic [NUM_EVT-1:0] on;
		logic [NUM_EVT-1:0] off;
		logic [31:0] stamp;
	} efd_evt_s;

	// Saturating counter step
	function automatic logic [15:0] efd_sat_inc(input logic [15:0] v);
		efd_sat_inc = (v == 16'hFFFF) ? v : v + 16'h0001;
	endfunction : efd_sat_inc

endpackage : efd_pkg

/* core/efd_delay_timer.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Fixed or inverse delay accumulator
// ****************************************
module efd_delay_timer
	import efd_pkg::*;
(
	input wire logic mclk, // System clock
	input wire logic rst_n, // Async reset, low
	input wire logic step, // Advance one program cycle
	input wire logic clear, // Restart from zero
	input wire efd_dly_e mode, // Fixed or inverse
	input wire logic [15:0] rate, // Inverse step size
	input wire logic [23:0] target, // Expiry level
	output logic [23:0] acc, // Accumulated time
	output logic done // Level reached
);

	logic [23:0] acc_q;
	logic [23:0] acc_d;
	wire [23:0] inc = (mode == FIXED_DELAY_MODE) ? 24'h00_0001 : {8'h00, rate};
	wire [24:0] sum = {1'b0, acc_q} + {1'b0, inc};

	// Saturate at target so the count never wraps
	assign acc_d = clear ? 24'h00_0000 :
		!step ? acc_q :
		(sum >= {1'b0, target}) ? target : sum[23:0];

	// Accumulator register
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			acc_q <= 24'h00_0000;
		end else begin
			acc_q <= acc_d;
		end
	end

	assign acc = acc_q;
	assign done = (acc_q >= target);

endmodule : efd_delay_timer
`default_nettype wire

/* core/efd_fault_record.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Circular fault record, newest first on read
// ****************************************
module efd_fault_record
	import efd_pkg::*;
(
	input wire logic mclk, // System clock
	input wire logic rst_n, // Async reset, low
	input wire logic wrEn, // Store one entry
	input wire efd_rec_s wrData, // Entry to store
	input wire logic [3:0] rdIdx, // 0 is newest
	output efd_rec_s rdData, // Registered read
	output logic [3:0] fill // Entries held
);

	// Memory has no reset; fill tells which entries are valid
	efd_rec_s mem [REC_DEPTH];
	logic [3:0] wrPtr_q;
	logic [3:0] fill_q;
	efd_rec_s rd_q;

	localparam logic [3:0] LAST = 4'(REC_DEPTH - 1);
	localparam logic [4:0] DEPTH5 = 5'(REC_DEPTH);

	// Oldest slot is overwritten once full
	wire [4:0] back = {1'b0, wrPtr_q} + DEPTH5 - 5'h01 - {1'b0, rdIdx};
	wire [3:0] rdAddr = (back >= DEPTH5) ? 4'(back - DEPTH5) : back[3:0];

	// Write pointer and fill level
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			wrPtr_q <= 4'h0;
			fill_q <= 4'h0;
			rd_q <= '0;
		end else begin
			if (wrEn) begin
				wrPtr_q <= (wrPtr_q == LAST) ? 4'h0 : wrPtr_q + 4'h1;
				fill_q <= (fill_q == 4'(REC_DEPTH)) ? fill_q : fill_q + 4'h1;
			end
			rd_q <= (rdIdx < fill_q) ? mem[rdAddr] : '0;
		end
	end

	// Storage array
	always_ff @(posedge mclk) begin
		if (wrEn) begin
			mem[wrPtr_q] <= wrData;
		end
	end

	assign rdData = rd_q;
	assign fill = fill_q;

endmodule : efd_fault_record
`default_nettype wire

/* core/efd_stage_bank.sv */
// Function
// - Sample blocking once per program cycle
// - Pick-up unblocked asserts start, runs delay
// - Pick-up while blocked asserts blocked only
// - Blocking during start drops start, releases
// - Inrush blocking enable, resets disabled
// - Inrush limit in 0.01 percent steps
// - Fixed or inverse delay, operate and reset
// - ON and OFF events per status output
// - Per-event mask for ON and OFF
// - Events carry time stamp of change
// - Counters for start, trip and blocked
// - Four independent stage instances
// - Twelve-entry circular fault record per stage
// - Record written on start/trip/blocked ON
// - Record holds currents, voltages, angle, time
// - Record holds setting group and grounding
// - Condition reads normal, start, trip, blocked
`timescale 1ns/1ps
`default_nettype none
module efd_stage_bank
	import efd_pkg::*;
(
	input wire logic mclk, // System clock, 10 MHz
	input wire logic rst_n, // Async reset, low
	input wire logic cycleStrobe, // Program cycle begins
	input wire logic [31:0] timeNow, // Running time stamp
	input wire efd_meas_s meas, // Process data
	input wire logic [15:0] harmRatio, // 2nd harm/fund, 0.01 %
	input wire logic [2:0] setGroup, // Active setting group
	input wire efd_gnd_e gndType, // Network grounding
	input wire logic [NUM_STAGES-1:0] cfgLoad, // Settings write strobe
	input wire efd_cfg_s cfgIn [NUM_STAGES], // Settings to load
	input wire logic [NUM_STAGES-1:0] blockIn, // From blocking matrix
	input wire logic [NUM_STAGES-1:0] pickUp, // Pick-up element
	input wire logic [NUM_STAGES-1:0] resPickUp, // Resistive part picked
	input wire logic [NUM_STAGES-1:0] capPickUp, // Capacitive part picked
	input wire logic [15:0] idmtRate [NUM_STAGES], // Inverse step size
	input wire logic [3:0] recIdx [NUM_STAGES], // Record read index
	output logic [NUM_STAGES-1:0] startOut, // Start status
	output logic [NUM_STAGES-1:0] tripOut, // Trip status
	output logic [NUM_STAGES-1:0] blockedOut, // Blocked status
	output efd_cond_e cond [NUM_STAGES], // Stage condition
	output efd_evt_s evt [NUM_STAGES], // Event pulses
	output logic [15:0] startCnt [NUM_STAGES], // Start count
	output logic [15:0] tripCnt [NUM_STAGES], // Trip count
	output logic [15:0] blockCnt [NUM_STAGES], // Blocked count
	output efd_rec_s recData [NUM_STAGES], // Record read data
	output logic [3:0] recFill [NUM_STAGES] // Records held
);

	// ****************************************
	// Shared residual current history
	// ****************************************

	// One word per program cycle; hist_q[k] is k+1 cycles old
	// Depth set by the longest pre-fault look-back
	logic [15:0] hist_q [PRE_FAULT_CYC];
	// Taps feed the record of every stage
	wire [15:0] preTrigNow = hist_q[PRE_TRIG_CYC-1];
	wire [15:0] preFaultNow = hist_q[PRE_FAULT_CYC-1];

	// Reset clears history, so early records read zero
	// History shift on each program cycle
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < PRE_FAULT_CYC; i++) begin
				hist_q[i] <= 16'h0000;
			end
		end else if (cycleStrobe) begin
			hist_q[0] <= meas.residualCurrent;
			for (int i = 1; i < PRE_FAULT_CYC; i++) begin
				hist_q[i] <= hist_q[i-1];
			end
		end
	end

	// ****************************************
	// Stage instances
	// ****************************************

	// Every stage shares measurements but keeps its own state
	for (genvar s = 0; s < NUM_STAGES; s++) begin : g_stage

		// Per-stage state; only measurements are shared
		efd_cfg_s cfg_q; // Loaded settings
		logic blk_q; // Sampled block
		logic [NUM_EVT-1:0] stat_q; // Status outputs
		logic [NUM_EVT-1:0] stat_d; // Status next
		efd_evt_s evt_q; // Event pulses
		logic [15:0] stCnt_q; // Start count
		logic [15:0] trCnt_q; // Trip count
		logic [15:0] bkCnt_q; // Blocked count
		logic [15:0] preFault_q; // Held at start
		logic [23:0] opAcc; // Operate time
		logic opDone; // Operate expired
		logic [23:0] rlAcc; // Release time
		logic rlDone; // Release expired

		// ****************************************
		// Settings and block sampling
		// ****************************************

		// Settings register; inrush starts disabled
		// A load takes effect on the next edge
		always_ff @(posedge mclk or negedge rst_n) begin
			if (!rst_n) begin
				cfg_q <= CFG_RST;
			end else if (cfgLoad[s]) begin
				cfg_q <= cfgIn[s];
			end
		end

		// Block is taken only at the cycle start and held
		// Held copy is what the stage sees between strobes
		always_ff @(posedge mclk or negedge rst_n) begin
			if (!rst_n) begin
				blk_q <= 1'b0;
			end else if (cycleStrobe) begin
				blk_q <= blockIn[s];
			end
		end

		// Live input is used on the strobe edge itself
		wire blkNow = cycleStrobe ? blockIn[s] : blk_q;
		// Start and blocked exclude each other by construction
		wire active = pickUp[s] & ~blkNow;
		wire blocked = pickUp[s] & blkNow;

		// Inrush affects trip only, never blocked output
		// A ratio equal to the limit already counts as inrush
		wire inrushSup = cfg_q.inrushEn & (harmRatio >= cfg_q.inrushLimit);

		// ****************************************
		// Operate and release timing
		// ****************************************

		// Both accumulators move only on strobe edges
		// Operate runs while started; released time wipes it
		wire opStep = cycleStrobe & active;
		wire opClr = cycleStrobe & ~active & rlDone;
		// Release runs after start drops, including by block
		wire rlStep = cycleStrobe & ~active & (opAcc != 24'h00_0000);
		// A fresh start abandons any release in progress
		wire rlClr = cycleStrobe & active;

		// Operate delay accumulator
		efd_delay_timer u_op (
			.mclk(mclk),
			.rst_n(rst_n),
			.step(opStep),
			.clear(opClr),
			.mode(cfg_q.opMode),
			.rate(idmtRate[s]),
			.target(cfg_q.opTarget),
			.acc(opAcc),
			.done(opDone)
		);

		// Release delay accumulator, same shape
		efd_delay_timer u_rl (
			.mclk(mclk),
			.rst_n(rst_n),
			.step(rlStep),
			.clear(rlClr),
			.mode(cfg_q.rstMode),
			.rate(idmtRate[s]),
			.target(cfg_q.rstTarget),
			.acc(rlAcc),
			.done(rlDone)
		);

		// ****************************************
		// Status outputs
		// ****************************************

		// Trip needs a start and an expired operate delay
		wire tripNow = active & opDone & ~inrushSup;
		// Component outputs follow the main start and trip
		assign stat_d[EVT_START] = active;
		assign stat_d[EVT_TRIP] = tripNow;
		assign stat_d[EVT_BLOCK] = blocked;
		assign stat_d[EVT_RES_START] = active & resPickUp[s];
		assign stat_d[EVT_CAP_START] = active & capPickUp[s];
		assign stat_d[EVT_RES_TRIP] = tripNow & resPickUp[s];
		assign stat_d[EVT_CAP_TRIP] = tripNow & capPickUp[s];

		// Status changes only once per program cycle
		always_ff @(posedge mclk or negedge rst_n) begin
			if (!rst_n) begin
				stat_q <= '0;
			end else if (cycleStrobe) begin
				stat_q <= stat_d;
			end
		end

		// Status edges, seen only on strobe edges
		// Gating by the strobe keeps a held status from firing again
		wire [NUM_EVT-1:0] rise = stat_d & ~stat_q & {NUM_EVT{cycleStrobe}};
		wire [NUM_EVT-1:0] fall = ~stat_d & stat_q & {NUM_EVT{cycleStrobe}};

		// ****************************************
		// Events
		// ****************************************

		// One-cycle pulses; stamp holds until the next change
		always_ff @(posedge mclk or negedge rst_n) begin
			if (!rst_n) begin
				evt_q <= '0;
			end else begin
				evt_q.on <= rise & cfg_q.maskOn;
				evt_q.off <= fall & cfg_q.maskOff;
				// Stamp follows any change, masked or not
				if ((rise | fall) != '0) begin
					evt_q.stamp <= timeNow;
				end
			end
		end

		// ****************************************
		// Counters
		// ****************************************

		// Saturate rather than wrap so a count never looks small
		// Limitation: a count at its top stays there until reset
		// Counted on rising status only; masks do not matter
		always_ff @(posedge mclk or negedge rst_n) begin
			if (!rst_n) begin
				stCnt_q <= 16'h0000;
				trCnt_q <= 16'h0000;
				bkCnt_q <= 16'h0000;
			end else begin
				if (rise[EVT_START]) stCnt_q <= efd_sat_inc(stCnt_q);
				if (rise[EVT_TRIP]) trCnt_q <= efd_sat_inc(trCnt_q);
				if (rise[EVT_BLOCK]) bkCnt_q <= efd_sat_inc(bkCnt_q);
			end
		end

		// ****************************************
		// Fault record
		// ****************************************

		// Pre-fault current is frozen at start for later trips
		always_ff @(posedge mclk or negedge rst_n) begin
			if (!rst_n) begin
				preFault_q <= 16'h0000;
			end else if (rise[EVT_START]) begin
				preFault_q <= preFaultNow;
			end
		end

		// Trip, start or blocked rising writes one entry
		// Only one entry per cycle: trip beats start beats blocked
		wire recWr = rise[EVT_START] | rise[EVT_TRIP] | rise[EVT_BLOCK];
		wire efd_cond_e recCause = rise[EVT_TRIP] ? COND_TRIP :
			rise[EVT_START] ? COND_START : COND_BLOCKED;
		// Remaining operate time; zero once expired
		wire [23:0] remain = opDone ? 24'h00_0000 : cfg_q.opTarget - opAcc;

		// Entry assembled from live data at the strobe edge
		efd_rec_s recIn;
		assign recIn.cause = recCause;
		assign recIn.stamp = timeNow;
		assign recIn.preTrig = preTrigNow;
		assign recIn.meas = meas;
		assign recIn.remaining = remain;
		assign recIn.setGroup = setGroup;
		assign recIn.gnd = gndType;
		assign recIn.preFault = rise[EVT_START] ? preFaultNow : preFault_q;

		// Twelve-deep ring per stage
		efd_fault_record u_rec (
			.mclk(mclk),
			.rst_n(rst_n),
			.wrEn(recWr),
			.wrData(recIn),
			.rdIdx(recIdx[s]),
			.rdData(recData[s]),
			.fill(recFill[s])
		);

		// ****************************************
		// Outputs
		// ****************************************

		// Status outputs straight from the flops
		assign startOut[s] = stat_q[EVT_START];
		assign tripOut[s] = stat_q[EVT_TRIP];
		assign blockedOut[s] = stat_q[EVT_BLOCK];
		// Blocked outranks trip, trip outranks start
		// Condition is a pure decode of the status flops
		assign cond[s] = stat_q[EVT_BLOCK] ? COND_BLOCKED :
			stat_q[EVT_TRIP] ? COND_TRIP :
			stat_q[EVT_START] ? COND_START : COND_NORMAL;
		// Events and counters straight from their registers
		assign evt[s] = evt_q;
		assign startCnt[s] = stCnt_q;
		assign tripCnt[s] = trCnt_q;
		assign blockCnt[s] = bkCnt_q;
	end

endmodule : efd_stage_bank
`default_nettype wire

/* tb/efd_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// Stage 0 port checker
// ****
module efd_monitor
	import efd_pkg::*;
(
	input wire logic mclk, // Clock
	input wire logic rst_n, // Reset, low
	input wire logic cycleStrobe, // Cycle start
	input wire logic [31:0] timeNow, // Stamp source
	input wire logic [NUM_STAGES-1:0] blockIn, // Block
	input wire logic [NUM_STAGES-1:0] pickUp, // Pick-up
	input wire logic [NUM_STAGES-1:0] startOut, // Start
	input wire logic [NUM_STAGES-1:0] tripOut, // Trip
	input wire logic [NUM_STAGES-1:0] blockedOut, // Blocked
	input wire efd_cond_e cond [NUM_STAGES], // Condition
	input wire efd_evt_s evt [NUM_STAGES], // Events
	input wire logic [15:0] startCnt [NUM_STAGES] // Start count
);
	// One clock domain for all
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	// Status only moves on a strobe edge
	property p_hold;
		!cycleStrobe |=> $stable(startOut) && $stable(tripOut) && $stable(blockedOut);
	endproperty
	a_hold: assert property (p_hold) else $error("status moved between strobes");
	property p_start;
		cycleStrobe && pickUp[0] && !blockIn[0] |=> startOut[0] && !blockedOut[0];
	endproperty
	a_start: assert property (p_start) else $error("no start on free pick-up");
	property p_blk;
		cycleStrobe && pickUp[0] && blockIn[0] |=> blockedOut[0] && !startOut[0] && !tripOut[0];
	endproperty
	a_blk: assert property (p_blk) else $error("blocked pick-up mishandled");
	// Trip needs a start held from an earlier cycle
	property p_trip;
		$rose(tripOut[0]) |-> startOut[0] && $past(startOut[0]);
	endproperty
	a_trip: assert property (p_trip) else $error("trip without earlier start");
	property p_onPulse;
		|evt[0].on |=> evt[0].on == '0;
	endproperty
	a_onPulse: assert property (p_onPulse) else $error("event pulse too long");
	property p_onCause;
		evt[0].on[EVT_START] |-> $rose(startOut[0]);
	endproperty
	a_onCause: assert property (p_onCause) else $error("start event without start");
	property p_stamp;
		evt[0].on[EVT_START] |-> evt[0].stamp == $past(timeNow);
	endproperty
	a_stamp: assert property (p_stamp) else $error("event stamp wrong");
	property p_cnt;
		$rose(startOut[0]) |-> startCnt[0] == $past(startCnt[0]) + 16'h0001;
	endproperty
	a_cnt: assert property (p_cnt) else $error("start count not stepped");
	property p_cond;
		cond[0] == (blockedOut[0] ? COND_BLOCKED : tripOut[0] ? COND_TRIP : startOut[0] ? COND_START : COND_NORMAL);
	endproperty
	a_cond: assert property (p_cond) else $error("condition decode wrong");
	// Main scenarios reached
	c_start: cover property ($rose(startOut[0]));
	c_trip: cover property ($rose(tripOut[0]));
	c_blk: cover property ($rose(blockedOut[0]));
endmodule : efd_monitor
bind efd_stage_bank efd_monitor u_mon (.mclk, .rst_n, .cycleStrobe, .timeNow, .blockIn, .pickUp,
	.startOut, .tripOut, .blockedOut, .cond, .evt, .startCnt);
`default_nettype wire

/* tb/efd_partner.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// Program cycle source and event buffer
// ****
module efd_partner
	import efd_pkg::*;
#(
	parameter int PERIOD = 8 // Clocks per program cycle, shortened
)
(
	input wire logic mclk, // Clock
	input wire logic rst_n, // Reset, low
	input wire efd_evt_s evt0, // Stage 0 events
	output logic cycleStrobe, // Cycle start pulse
	output logic [31:0] timeNow, // Free running stamp
	output logic [7:0] evCount // Events buffered
);
	logic [7:0] div_q; // Strobe divider
	// Short cycle keeps the run brief; spacing stays above two clocks
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			div_q <= 8'h00;
			cycleStrobe <= 1'b0;
			timeNow <= 32'h0000_0000;
			evCount <= 8'h00;
		end else begin
			timeNow <= timeNow + 32'h0000_0001;
			div_q <= (div_q == 8'(PERIOD - 1)) ? 8'h00 : div_q + 8'h01;
			cycleStrobe <= (div_q == 8'(PERIOD - 1));
			evCount <= evCount + 8'($countones({evt0.on, evt0.off}));
		end
	end
endmodule : efd_partner
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import efd_pkg::*;
;
	// ****
	// Stimulus and outputs
	// ****
	logic mclk = 1'b0, rst_n = 1'b0, cycleStrobe;
	logic [31:0] timeNow, ts;
	logic [31:0] stamps [13]; // Entry stamps in order
	efd_meas_s meas = '{default: 16'h00A5}; // Fixed process data
	logic [15:0] harmRatio = 16'h0000;
	logic [2:0] setGroup = 3'h5;
	efd_gnd_e gndType = GND_COIL;
	logic [NUM_STAGES-1:0] cfgLoad = '0, blockIn = '0, pickUp = '0, resPickUp = '0, capPickUp = '0;
	efd_cfg_s cfgIn [NUM_STAGES] = '{default: CFG_RST};
	efd_cfg_s c; // Settings being built
	logic [15:0] idmtRate [NUM_STAGES] = '{default: 16'h0003};
	logic [3:0] recIdx [NUM_STAGES] = '{default: 4'h0};
	logic [NUM_STAGES-1:0] startOut, tripOut, blockedOut;
	efd_cond_e cond [NUM_STAGES];
	efd_evt_s evt [NUM_STAGES];
	logic [15:0] startCnt [NUM_STAGES], tripCnt [NUM_STAGES], blockCnt [NUM_STAGES];
	efd_rec_s recData [NUM_STAGES];
	logic [3:0] recFill [NUM_STAGES];
	logic [7:0] evCount;
	int nMismatch = 0, samplesChecked = 0;
	always #50 mclk = ~mclk;
	efd_stage_bank u_dut (.mclk, .rst_n, .cycleStrobe, .timeNow, .meas, .harmRatio, .setGroup, .gndType,
		.cfgLoad, .cfgIn, .blockIn, .pickUp, .resPickUp, .capPickUp, .idmtRate, .recIdx, .startOut,
		.tripOut, .blockedOut, .cond, .evt, .startCnt, .tripCnt, .blockCnt, .recData, .recFill);
	efd_partner u_far (.mclk, .rst_n, .evt0(evt[0]), .cycleStrobe, .timeNow, .evCount);
	// ****
	// Helpers
	// ****
	task summarize();
		if (nMismatch == 0 && samplesChecked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : summarize
	task chk(input logic ok);
		samplesChecked++;
		if (ok !== 1'b1) begin
			nMismatch++;
			$display("ERROR %0t output differs from expectation", $time);
		end
	endtask : chk
	task drv(input logic [3:0] p, input logic [3:0] b);
		@(posedge mclk);
		pickUp <= p;
		blockIn <= b;
	endtask : drv
	// Waits n strobes, keeps last stamp, lets outputs settle
	task tick(input int n);
		repeat (n) begin
			@(posedge mclk iff cycleStrobe);
			ts = timeNow;
		end
		#1;
	endtask : tick
	task ld(input int s, input efd_cfg_s v);
		@(posedge mclk);
		cfgIn[s] <= v;
		cfgLoad[s] <= 1'b1;
		@(posedge mclk);
		cfgLoad[s] <= 1'b0;
	endtask : ld
	task rd(input logic [3:0] i);
		@(posedge mclk);
		recIdx[0] <= i;
		repeat (2) @(posedge mclk);
		#1;
	endtask : rd
	// ****
	// Scenarios
	// ****
	task t_start();
		drv(4'h7, 4'h0);
		tick(1);
		chk(startOut === 4'b0111);
		chk(evt[0].on[EVT_START] === 1'b1 && evt[0].stamp === ts);
		chk(evt[1].on === 7'h00 && startCnt[1] === 16'h0001);
		chk(cond[0] === COND_START);
		rd(4'h0);
		chk(evCount === 8'h01);
		chk(recData[0].cause === COND_START && recData[0].stamp === ts && recFill[0] === 4'h1);
		chk(recData[0].meas === meas && recData[0].setGroup === 3'h5 && recData[0].gnd === GND_COIL);
	endtask : t_start
	task t_trip();
		// A delay of two cycles trips on the second strobe after start
		tick(1);
		chk(tripOut === 4'h0);
		tick(1);
		chk(tripOut === 4'b0101 && evt[0].on[EVT_TRIP] === 1'b1 && tripCnt[0] === 16'h0001);
		chk(cond[0] === COND_TRIP);
	endtask : t_trip
	task t_block();
		drv(4'h7, 4'h1);
		tick(1);
		chk(startOut[0] === 1'b0 && tripOut[0] === 1'b0 && blockedOut[0] === 1'b1);
		chk(evt[0].off[EVT_START] === 1'b1 && evt[0].on[EVT_BLOCK] === 1'b1 && blockCnt[0] === 16'h0001);
		rd(4'h0);
		chk(recData[0].cause === COND_BLOCKED && recFill[0] === 4'h3);
		drv(4'h0, 4'h0);
		tick(1);
		chk(blockedOut === 4'b0000 && evt[0].off[EVT_BLOCK] === 1'b1);
	endtask : t_block
	task t_sample();
		drv(4'h1, 4'h1);
		drv(4'h1, 4'h0);
		resPickUp <= 4'h1;
		capPickUp <= 4'h1;
		tick(1);
		chk(startOut[0] === 1'b1 && blockedOut[0] === 1'b0 && startCnt[0] === 16'h0002);
		chk(evt[0].on[EVT_RES_START] === 1'b1 && evt[0].on[EVT_CAP_START] === 1'b1);
	endtask : t_sample
	task t_inrush();
		drv(4'h0, 4'h0);
		tick(2);
		c.inrushEn = 1'b1;
		c.inrushLimit = 16'h0500;
		ld(0, c);
		@(posedge mclk);
		harmRatio <= 16'h0500;
		drv(4'h9, 4'h0);
		tick(4);
		chk(startOut[0] === 1'b1 && tripOut[0] === 1'b0 && tripOut[3] === 1'b1);
		@(posedge mclk);
		harmRatio <= 16'h04FF;
		tick(1);
		chk(tripOut[0] === 1'b1);
		chk(evt[0].on[EVT_RES_TRIP] === 1'b1 && evt[0].on[EVT_CAP_TRIP] === 1'b1);
	endtask : t_inrush
	task t_wrap();
		for (int k = 0; k < 13; k++) begin
			drv(4'h0, 4'h0);
			tick(1);
			drv(4'h1, 4'h0);
			tick(1);
			stamps[k] = ts;
		end
		rd(4'h0);
		chk(recData[0].stamp === stamps[12] && recFill[0] === 4'hC);
		chk(recData[0].preTrig === meas.residualCurrent && recData[0].remaining === c.opTarget);
		rd(4'hB);
		chk(recData[0].stamp === stamps[1]);
	endtask : t_wrap
	// ****
	// Main sequence and watchdog
	// ****
	initial begin
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		c = CFG_RST;
		c.maskOn = 7'h7F;
		c.maskOff = 7'h7F;
		c.opTarget = 24'h00_0002;
		ld(0, c);
		c.maskOn = 7'h00;
		c.opTarget = 24'h00_0100;
		ld(1, c);
		c.maskOn = 7'h7F;
		c.opMode = INVERSE_DELAY_MODE;
		c.opTarget = 24'h00_0006;
		ld(2, c);
		c.opMode = FIXED_DELAY_MODE;
		c.opTarget = 24'h00_0002;
		t_start();
		t_trip();
		t_block();
		t_sample();
		t_inrush();
		t_wrap();
		summarize();
	end
	// Run needs about three hundred and thirty clocks; six times that is a hang
	initial begin
		repeat (2000) @(posedge mclk);
		nMismatch++;
		summarize();
	end
endmodule : tb_top
`default_nettype wire
